// ---- reset_irq_lowpower_timing_tb.sv ----
// Purpose: self-checking bench for the sequencer
// Assumes: stop long delay shortened to 16 bus cycles
// Notes:   inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module reset_irq_lowpower_timing_tb;
    import rilt_pkg::*;
    localparam int STOP_LONG = 16;
    logic           clk_sys = 1'h0, reset = 1'h1, pin, oe, pin_o, irq_n, nmi_n, edge_sel;
    logic           delay_sel, mask_bit, wait_req, stop_req, pacc, pend, serv, run, tick;
    logic           mode_a, mode_b;
    rilt_rst_info_t rst_info;
    logic [15:0]    pacc_count;
    int             n_errors = 0, total_checks = 0, n, lim, model_pacc = 0, hold[2] = '{12, 1};
    always #5 clk_sys = ~clk_sys;
    rilt_board rilt_board_inst (.clk_sys(clk_sys), .dev_oe(oe), .pin(pin));
    rilt_seq #(.STOP_LONG_CYC(STOP_LONG)) rilt_seq_inst (.clk_sys(clk_sys), .reset(reset),
        .reset_pin_i(pin), .reset_pin_o(pin_o), .reset_pin_oe(oe), .mode_a_i(mode_a),
        .mode_b_i(mode_b), .irq_n_i(irq_n), .nonmaskable_irq_pin(nmi_n), .pacc_i(pacc),
        .irq_edge_select(edge_sel), .stop_delay_select(delay_sel), .wait_req(wait_req),
        .condition_code_reg(mask_bit), .stop_req(stop_req), .irq_pending(pend),
        .nonmaskable_irq_pin_service(serv), .cpu_run(run), .bus_clk_en(tick), .rst_info(rst_info),
        .pacc_count(pacc_count));
    task automatic chk(input logic [15:0] exp, input logic [15:0] act);
        total_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, act);
        end
    endtask
    task automatic wait_for(input logic want, output int cyc);
        cyc = 0;
        while (run !== want && cyc < 400) begin
            @(negedge clk_sys);
            cyc++;
        end
        // A wait that runs out counts as a mismatch
        if (run !== want) n_errors++;
    endtask
    task automatic do_reset;
        @(negedge clk_sys) reset = 1'h1;
        {irq_n, nmi_n, edge_sel, delay_sel, mask_bit, wait_req, stop_req, pacc} = 8'hC0;
        {mode_a, mode_b} = 2'($urandom);
        repeat (6) @(negedge clk_sys);
        reset = 1'h0;
        wait_for(1'b1, n);
    endtask
    task automatic sleep(input logic to_stop);
        {wait_req, stop_req} = {!to_stop, to_stop};
        wait_for(1'b0, n);
        {wait_req, stop_req} = 2'h0;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(94756));
        do_reset;
        chk({13'h0, 1'b0, mode_a, mode_b}, {13'h0, rst_info});
        foreach (hold[i]) begin
            rilt_board_inst.pull_low(hold[i]);
            wait_for(1'b1, n);
            chk({15'h0, hold[i] >= 8}, {15'h0, rst_info.ext_vector});
        end
        sleep(1'b0);
        irq_n = 1'h0;
        wait_for(1'b1, n);
        chk(16'h1, {15'h0, n <= 20});
        do_reset;
        sleep(1'b0);
        rilt_board_inst.pull_low(1);
        chk(16'h1, {15'h0, oe});
        for (int d = 0; d < 2; d++) begin
            do_reset;
            {delay_sel, mask_bit} = {d[0], d[0]};
            sleep(1'b1);
            nmi_n = 1'h0;
            wait_for(1'b1, n);
            // Service flag stands only until the first bus cycle in run
            chk({15'h0, !d[0]}, {15'h0, serv});
            nmi_n = 1'h1;
            lim = (d ? STOP_LONG : 4) * 4;
            chk(16'h1, {15'h0, n >= lim - 4 && n <= lim + 16});
        end
        do_reset;
        edge_sel = 1'h1;
        repeat (8) @(negedge clk_sys);
        chk(16'h0, {15'h0, pend});
        irq_n = 1'h0;
        lim = 0;
        while (pend !== 1'b1 && lim < 8) begin
            @(negedge clk_sys);
            lim++;
        end
        chk(16'h1, {15'h0, pend});
        // Line still low but no new edge, so nothing may be latched again
        repeat (8) @(negedge clk_sys);
        chk(16'h0, {15'h0, pend});
        irq_n = 1'h1;
        repeat (40) begin
            pacc = ~pacc;
            if (pacc) model_pacc++;
            repeat (6 + $urandom_range(0, 6)) @(negedge clk_sys);
        end
        chk(16'(model_pacc), pacc_count);
        test_done;
    end
    // Whole run needs well under 3000 cycles
    initial begin
        #100000;
        n_errors++;
        test_done;
    end
endmodule
`default_nettype wire

// ---- rilt_board.sv ----
// Purpose: board reset circuit on the open-drain pin
// Assumes: pull-up on the pin
// Notes:   pin reads high once nobody pulls it
`timescale 1ns/100ps
`default_nettype none
module rilt_board (
    input  wire logic clk_sys, // Clock
    input  wire logic dev_oe,  // Device pulls low
    output logic      pin      // Resolved level
);
    logic ext_low = 1'h0;
    assign pin = !(dev_oe || ext_low);
    task automatic pull_low(input int ticks);
        @(negedge clk_sys) ext_low = 1'h1;
        repeat (ticks * 4) @(negedge clk_sys);
        ext_low = 1'h0;
    endtask
endmodule
`default_nettype wire

// ---- rilt_clkdiv.sv ----
// Purpose: bus clock enable derived from the oscillator
// Assumes: synchronous active-high reset
// Notes:   tick is a one-cycle pulse every DIV oscillator cycles
`timescale 1ns/100ps
`default_nettype none
`include "rilt_defs.svh"
module rilt_clkdiv #(
    parameter int DIV = `RILT_BUS_DIV
) (
    input  wire logic clk_sys,   // Oscillator clock
    input  wire logic reset,     // Synchronous reset
    output logic      bus_tick   // Bus cycle pulse
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk_sys) begin
        if (reset || cnt_q == 8'(DIV - 1)) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign bus_tick = (cnt_q == 8'(DIV - 1));
endmodule
`default_nettype wire

// ---- rilt_defs.svh ----
// Purpose: constants for the reset, interrupt and low-power sequencer
// Assumes: clk_sys at 100 MHz stands for the oscillator input
// Notes:   counts are in bus cycles unless marked otherwise
`ifndef RILT_DEFS_SVH
`define RILT_DEFS_SVH
`define RILT_CLK_PERIOD_NS   10
`define RILT_BUS_DIV         4
`define RILT_RST_DRIVE_CYC   4
`define RILT_RST_SAMPLE_CYC  2
`define RILT_RST_EXT_MIN     8
`define RILT_MODE_SETUP_CYC  2
`define RILT_WAIT_RESUME_CYC 4
`define RILT_STOP_LONG_CYC   4064
`define RILT_STOP_SHORT_CYC  4
`define RILT_PULSE_EXTRA_NS  20
`endif

// ---- rilt_monitor.sv ----
// Purpose: port checker for the sequencer
// Assumes: one clock domain, synchronous reset
// Notes:   bound to rilt_seq below
`timescale 1ns/100ps
`default_nettype none
module rilt_monitor (
    input wire logic clk_sys,            // Clock
    input wire logic reset,              // Reset
    input wire logic reset_pin_i,        // Pin level
    input wire logic reset_pin_o,        // Pin value
    input wire logic reset_pin_oe,       // Pin drive
    input wire logic irq_n_i,            // Request pin
    input wire logic irq_edge_select,    // Edge mode
    input wire logic condition_code_reg, // Mask bit
    input wire logic irq_pending,        // Latched request
    input wire logic nonmaskable_irq_pin_service,       // Service flag
    input wire logic cpu_run,            // Core running
    input wire logic bus_clk_en          // Bus tick
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [2:0] oe_cnt_q;
    logic       irq_prev_q;
    // Wraps if the drive sticks, so a drive of 12 bus cycles reads 4 again and passes the length check
    always_ff @(posedge clk_sys) begin
        if (reset || !reset_pin_oe) oe_cnt_q <= 3'h0;
        else if (bus_clk_en) oe_cnt_q <= oe_cnt_q + 3'h1;
    end
    // Starts high so a line already low from reset counts as an edge on the first bus tick
    always_ff @(posedge clk_sys) begin
        if (reset) irq_prev_q <= 1'h1;
        else if (bus_clk_en) irq_prev_q <= irq_n_i;
    end
    tick_gap_a: assert property (bus_clk_en |=> !bus_clk_en [*3] ##1 bus_clk_en)
        else $error("bus tick spacing wrong");
    open_drain_a: assert property (reset_pin_o == 1'b0)
        else $error("reset pin value not low");
    drive_len_a: assert property ($fell(reset_pin_oe) |-> oe_cnt_q == 3'h4)
        else $error("reset drive length wrong");
    sample_gap_a: assert property ($fell(reset_pin_oe) |-> !cpu_run [*8])
        else $error("run before pin sample");
    release_run_a: assert property ($fell(reset_pin_oe) ##7 reset_pin_i |=> cpu_run)
        else $error("no run after pin sample");
    reset_seen_a: assert property (cpu_run && bus_clk_en && !reset_pin_i |=> reset_pin_oe)
        else $error("low pin not recognised");
    level_irq_a: assert property (bus_clk_en && !irq_edge_select && !irq_n_i |=> irq_pending)
        else $error("level request missed");
    irq_cause_a: assert property ($rose(irq_pending) |-> $past(bus_clk_en) &&
        !$past(irq_n_i) && (!$past(irq_edge_select) || $past(irq_prev_q)))
        else $error("request without cause");
    nmi_mask_a: assert property ($rose(nonmaskable_irq_pin_service) |-> !$past(condition_code_reg))
        else $error("masked request serviced");
endmodule
bind rilt_seq rilt_monitor rilt_monitor_inst (.clk_sys(clk_sys), .reset(reset),
    .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
    .irq_n_i(irq_n_i), .irq_edge_select(irq_edge_select), .irq_pending(irq_pending),
    .condition_code_reg(condition_code_reg), .nonmaskable_irq_pin_service(nonmaskable_irq_pin_service),
    .cpu_run(cpu_run), .bus_clk_en(bus_clk_en));
`default_nettype wire

// ---- rilt_pkg.sv ----
// Purpose: shared types for the sequencer
// Assumes: nothing beyond the defs header
// Notes:   none
package rilt_pkg;
    typedef enum logic [2:0] {
        RILT_RUN      = 3'b000,
        RILT_RST_DRV  = 3'b001,
        RILT_RST_WAIT = 3'b010,
        RILT_WAIT     = 3'b011,
        RILT_STOP     = 3'b100,
        RILT_STOP_DLY = 3'b101,
        RILT_RESUME   = 3'b110
    } rilt_state_t;

    typedef struct packed {
        logic ext_vector;
        logic mode_a;
        logic mode_b;
    } rilt_rst_info_t;
endpackage

// ---- rilt_seq.sv ----
// Behaviour
// - External reset is recognised in the first bus cycle the pin is seen low.
// - The pin is then driven low for four bus cycles, released, and sampled two cycles later.
// - A low of eight bus cycles or more selects the external reset vector; one cycle is accepted.
// - Leaving wait on an interrupt resumes within four bus cycles.
// - The reset pin also ends the wait state.
// - Stop recovery waits 4064 bus cycles with stop delay select set, else four.
// - The maskable request reacts to falling edges when edge select is set, else to low level.
// - The accumulator counts at most at half the bus rate.
//
// Purpose: reset pin, interrupt and low-power sequencing
// Assumes: all inputs synchronous to clk_sys, sampled on bus ticks
// Notes:   one bus cycle is one bus_tick; reset input is the power-on reset
`timescale 1ns/100ps
`default_nettype none
`include "rilt_defs.svh"
module rilt_seq
    import rilt_pkg::*;
#(
    parameter int STOP_LONG_CYC = `RILT_STOP_LONG_CYC
) (
    input  wire logic     clk_sys,             // Oscillator clock
    input  wire logic     reset,               // Power-on reset
    input  wire logic     reset_pin_i,         // Reset pin level
    output logic          reset_pin_o,         // Reset pin output value
    output logic          reset_pin_oe,        // Reset pin drive enable
    input  wire logic     mode_a_i,            // Mode pin A
    input  wire logic     mode_b_i,            // Mode pin B
    input  wire logic     irq_n_i,             // Maskable request pin
    input  wire logic     nonmaskable_irq_pin, // Nonmaskable request pin, low active
    input  wire logic     irq_edge_select,     // 1 edge, 0 level
    input  wire logic     stop_delay_select,   // 1 long stop delay
    input  wire logic     condition_code_reg,  // Nonmaskable mask bit
    input  wire logic     wait_req,            // Core enters wait
    input  wire logic     stop_req,            // Core enters stop
    input  wire logic     pacc_i,              // Pulse accumulator input
    output logic          irq_pending,         // Maskable request latched
    output logic          nonmaskable_irq_pin_service,        // Nonmaskable to be serviced
    output logic          cpu_run,             // Core may execute
    output logic          bus_clk_en,          // Bus cycle pulse
    output rilt_rst_info_t rst_info,           // Reset source and mode
    output logic [15:0]   pacc_count           // Accumulated events
);
    rilt_state_t state_q;
    logic [11:0] cnt_q;
    logic [3:0]  low_cnt_q;
    logic        irq_prev_q;
    logic        pacc_prev_q;
    logic        tick;
    logic        irq_evt;
    logic        nonmaskable_irq_pin_evt;

    rilt_clkdiv #(
        .DIV (`RILT_BUS_DIV)
    ) u_div (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .bus_tick (tick)
    );

    assign bus_clk_en   = tick;
    assign reset_pin_o  = 1'b0;
    assign reset_pin_oe = (state_q == RILT_RST_DRV);
    assign cpu_run      = (state_q == RILT_RUN);

    // Edge seen only across bus ticks, so a pulse shorter than a bus cycle may be missed
    assign irq_evt  = irq_edge_select ? (irq_prev_q && !irq_n_i) : !irq_n_i;
    assign nonmaskable_irq_pin_evt = !nonmaskable_irq_pin;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_prev_q  <= 1'b1;
            irq_pending <= 1'b0;
        end else if (tick) begin
            irq_prev_q <= irq_n_i;
            if (irq_evt) begin
                irq_pending <= 1'b1;
            end else if (cpu_run) begin
                irq_pending <= 1'b0;
            end
        end
    end

    // Counts bus cycles the pin stays low, our own drive included, saturating at 15
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            low_cnt_q <= 4'h0;
        end else if (tick) begin
            if (reset_pin_i) begin
                low_cnt_q <= 4'h0;
            end else if (low_cnt_q != 4'hF) begin
                low_cnt_q <= low_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= RILT_RST_DRV;
            cnt_q   <= 12'h000;
        end else if (tick) begin
            unique case (state_q)
                RILT_RUN: begin
                    cnt_q <= 12'h000;
                    if (!reset_pin_i) begin
                        state_q <= RILT_RST_DRV;
                    end else if (stop_req) begin
                        state_q <= RILT_STOP;
                    end else if (wait_req) begin
                        state_q <= RILT_WAIT;
                    end
                end
                RILT_RST_DRV: begin
                    if (cnt_q == 12'(`RILT_RST_DRIVE_CYC - 1)) begin
                        cnt_q   <= 12'h000;
                        state_q <= RILT_RST_WAIT;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                RILT_RST_WAIT: begin
                    if (cnt_q == 12'(`RILT_RST_SAMPLE_CYC - 1)) begin
                        cnt_q <= 12'h000;
                        if (reset_pin_i) begin
                            state_q <= RILT_RUN;
                        end
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                RILT_WAIT: begin
                    if (!reset_pin_i) begin
                        state_q <= RILT_RST_DRV;
                    end else if (irq_evt || nonmaskable_irq_pin_evt) begin
                        cnt_q   <= 12'h000;
                        state_q <= RILT_RESUME;
                    end
                end
                RILT_RESUME: begin
                    if (!reset_pin_i) begin
                        cnt_q   <= 12'h000;
                        state_q <= RILT_RST_DRV;
                    end else if (cnt_q == 12'(`RILT_WAIT_RESUME_CYC - 2)) begin
                        state_q <= RILT_RUN;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                RILT_STOP: begin
                    cnt_q <= 12'h000;
                    if (!reset_pin_i) begin
                        state_q <= RILT_RST_DRV;
                    end else if (irq_evt || nonmaskable_irq_pin_evt) begin
                        state_q <= RILT_STOP_DLY;
                    end
                end
                RILT_STOP_DLY: begin
                    // A reset must not wait out the long start-up delay
                    if (!reset_pin_i) begin
                        cnt_q   <= 12'h000;
                        state_q <= RILT_RST_DRV;
                    end else if (cnt_q == (stop_delay_select ? 12'(STOP_LONG_CYC - 1)
                                  : 12'(`RILT_STOP_SHORT_CYC - 1))) begin
                        state_q <= RILT_RUN;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                default: begin
                    state_q <= RILT_RST_DRV;
                end
            endcase
        end
    end

    // Source cleared when a new reset is seen, so a short one never keeps a stale long verdict
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rst_info <= '0;
        end else if (tick) begin
            if (!reset_pin_i && state_q != RILT_RST_DRV && state_q != RILT_RST_WAIT) begin
                rst_info.ext_vector <= 1'b0;
            end else if (state_q == RILT_RST_WAIT && !reset_pin_i
                         && low_cnt_q >= 4'(`RILT_RST_EXT_MIN - 1)) begin
                rst_info.ext_vector <= 1'b1;
            end else if (state_q == RILT_RST_WAIT && reset_pin_i
                         && cnt_q == 12'(`RILT_RST_SAMPLE_CYC - 1)) begin
                rst_info.mode_a <= mode_a_i;
                rst_info.mode_b <= mode_b_i;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            nonmaskable_irq_pin_service <= 1'b0;
        end else if (tick && state_q == RILT_STOP && nonmaskable_irq_pin_evt) begin
            nonmaskable_irq_pin_service <= !condition_code_reg;
        end else if (tick && cpu_run) begin
            nonmaskable_irq_pin_service <= 1'b0;
        end
    end

    // Sampling once per bus cycle on alternate edges caps the rate at half the bus clock
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pacc_prev_q <= 1'b0;
            pacc_count  <= 16'h0000;
        end else if (tick) begin
            pacc_prev_q <= pacc_i;
            if (pacc_i && !pacc_prev_q) begin
                pacc_count <= pacc_count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire
